//--- core/vectored_irq_priority_map.sv
// Interrupt request mapping, level selection and vector generation
`timescale 1ns/1ns
module vectored_irq_priority_map (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Peripheral request levels
  input irq_map_pkg::src_t src_i,
  // Vector fetch acknowledge from the CPU core
  input wire logic take_i,
  // Grant towards the CPU core
  output irq_map_pkg::grant_t grant_o,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Interrupt line
  output logic irq_o
);
  import irq_map_pkg::*;

  // Peripheral lines are folded onto 24 numbered requests, the enabled
  // ones are ranked by level and number, and the winner is offered to
  // the core as a registered grant carrying its vector pair. The core
  // answers with take_i, which only feeds the overrun event.

  // ---------------------------------------------------------------
  // Request mapping
  // ---------------------------------------------------------------
  logic [NUM_REQ-1:0] req; // Raw request lines
  always_comb begin
    req = '0; // Lines without source stay low
    req[REQ_EXT4] = src_i.ext4;
    req[REQ_EXT5] = src_i.ext5;
    req[REQ_EXT26] = src_i.ext2 | src_i.ext6;
    req[REQ_EXT37] = src_i.ext3 | src_i.ext7;
    req[REQ_TMR0_LO] = src_i.tmr0_lo;
    req[REQ_TMR0_HI] = src_i.tmr0_hi;
    req[REQ_TMR1_HI] = src_i.tmr1_hi;
    req[REQ_TMR1_LO] = src_i.tmr1_lo;
    req[REQ_SER_RX] = src_i.ser_rx;
    req[REQ_SER_TX] = src_i.ser_tx;
    req[REQ_ADC] = src_i.adc;
    req[REQ_TBT] = src_i.tbt;
    req[REQ_WPS] = src_i.wps;
    req[REQ_FLASH] = src_i.flash;
  end

  // ---------------------------------------------------------------
  // Level fields, two bits per request
  // ---------------------------------------------------------------
  logic [2*NUM_REQ-1:0] level; // Level fields, request n at [2n+1:2n]
  logic [NUM_REQ-1:0] mask; // Request enable per line
  logic [1:0] status; // Sticky event bits
  logic [1:0] irq_mask; // Event interrupt mask

  // ---------------------------------------------------------------
  // Arbiter: lowest level value wins, lowest number on a tie
  // ---------------------------------------------------------------
  // Level value 0 is the most urgent. The order is fixed, so a busy low
  // number can starve higher numbers that sit at the same level.
  logic found; // Any enabled request active
  logic [4:0] best_num; // Winning request number
  logic [1:0] best_lvl; // Winning level
  logic [NUM_REQ-1:0] live; // Enabled active requests
  assign live = req & mask;
  always_comb begin
    found = 1'b0;
    best_num = 5'h00;
    best_lvl = 2'h3;
    // Scan from 23 down so lower numbers overwrite on ties
    for (int i = NUM_REQ - 1; i >= 0; i--) begin
      if (live[i] && (!found || level[2*i +: 2] <= best_lvl)) begin
        found = 1'b1;
        best_num = 5'(i);
        best_lvl = level[2*i +: 2];
      end
    end
  end

  // Vector pair for the winner: upper byte first
  logic [15:0] vec_hi; // Address of the upper vector byte
  assign vec_hi = VEC_BASE - 16'({best_num, 1'b0});

  // ---------------------------------------------------------------
  // Registered grant
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      grant_o <= '0;
    end else begin
      grant_o.valid <= found;
      grant_o.num <= best_num;
      grant_o.level <= best_lvl;
      grant_o.vec_upper <= vec_hi;
      grant_o.vec_lower <= vec_hi + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------
  // A new winner is flagged when the grant changes hands, not while
  // the same request keeps standing, so software sees one event per
  // handover.
  logic [4:0] last_num; // Winner seen last cycle
  logic last_valid; // Winner present last cycle
  logic [NUM_REQ-1:0] req_q; // Request lines last cycle
  wire ev_win = found && (!last_valid || best_num != last_num);
  // A live request rising in the same cycle as the core takes the standing grant
  wire ev_ovr = take_i && grant_o.valid && |(req & ~req_q & live);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // A request is answered one cycle after it is seen; the write itself
  // lands on the edge at which the master samples ack high, so a
  // register changes only once the master can see that it was taken
  wire bus_req = cyc_i && stb_i && !ack_o; // New request, not yet answered
  wire wr = cyc_i && stb_i && we_i && ack_o; // Write on the ack edge
  wire hit_l0 = adr_i == ADDR_LEVEL0;
  wire hit_l1 = adr_i == ADDR_LEVEL1;
  wire hit_pend = adr_i == ADDR_PENDING;
  wire hit_st = adr_i == ADDR_STATUS;
  wire hit_mask = adr_i == ADDR_MASK;
  wire hit_win = adr_i == ADDR_WINNER;
  wire [31:0] rd_data =
    hit_l0 ? {8'h00, level[23:0]} :
    hit_l1 ? {8'h00, level[47:24]} :
    hit_pend ? {8'h00, req} :
    hit_st ? {30'h0, status} :
    hit_mask ? {6'h00, irq_mask, mask} :
    hit_win ? {8'h00, grant_o.vec_upper, grant_o.valid, grant_o.level,
               grant_o.num} :
    32'h0;
  wire [1:0] st_clr = (wr && hit_st && sel_i[0]) ? dat_i[1:0] : 2'h0;
  wire [1:0] st_set = {ev_ovr, ev_win};

  // Bus ack, registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= bus_req;
      dat_o <= bus_req ? rd_data : 32'h0;
    end
  end

  // Level fields, byte-lane writes; reset to lowest priority level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level <= {NUM_REQ{LEVEL_RESET}};
    end else begin
      for (int b = 0; b < 3; b++) begin
        if (wr && hit_l0 && sel_i[b]) level[8*b +: 8] <= dat_i[8*b +: 8];
        if (wr && hit_l1 && sel_i[b])
          level[24 + 8*b +: 8] <= dat_i[8*b +: 8];
      end
    end
  end

  // Mask registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= '1;
      irq_mask <= 2'h0;
    end else if (wr && hit_mask) begin
      for (int b = 0; b < 3; b++) begin
        if (sel_i[b]) mask[8*b +: 8] <= dat_i[8*b +: 8];
      end
      if (sel_i[3]) irq_mask <= dat_i[25:24];
    end
  end

  // An event that lands together with its own clear is not lost
  // Sticky status: set wins over write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= 2'h0;
      last_num <= 5'h00;
      last_valid <= 1'b0;
      req_q <= '0;
    end else begin
      status <= (status & ~st_clr) | st_set;
      last_num <= best_num;
      last_valid <= found;
      req_q <= req;
    end
  end

  assign irq_o = |(status & irq_mask);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ext_shared: assert property (
    src_i.ext6 && mask[REQ_EXT26] |-> found)
    else $error("shared external request not raised");
  chk_ext_direct: assert property (
    src_i.ext4 && mask[REQ_EXT4] && level[1:0] == 2'h0
    |=> grant_o.num == 5'h00)
    else $error("channel 4 did not win at level 0");
  // Any live line that should have beaten the winner: a lower level
  // value, or the same level with a lower request number
  logic arb_bad; // Arbitration result broken
  always_comb begin
    arb_bad = 1'b0;
    for (int i = 0; i < NUM_REQ; i++) begin
      if (found && live[i] && level[2*i +: 2] < best_lvl) begin
        arb_bad = 1'b1; // A better level was passed over
      end
      if (found && live[i] && level[2*i +: 2] == best_lvl
          && 5'(i) < best_num) begin
        arb_bad = 1'b1; // A lower number lost a tie
      end
    end
  end
  chk_tie_order: assert property (found |-> !arb_bad)
    else $error("tie order broken");
  chk_lower_win: assert property (
    found |-> !(best_num > 0 && live[0] && level[1:0] <= best_lvl))
    else $error("request 0 lost a tie");
  chk_vec_pair: assert property (
    grant_o.valid |-> grant_o.vec_lower == grant_o.vec_upper + 16'h1
      && grant_o.vec_upper == 16'hfffa - {10'h0, grant_o.num, 1'b0})
    else $error("vector pair wrong");
  chk_grant_lag: assert property (
    found |=> grant_o.valid && grant_o.level == $past(best_lvl))
    else $error("grant did not follow arbiter");
  chk_timer_map: assert property (
    src_i.tmr1_lo && live[REQ_TMR1_LO] && !(|live[21:0]) && !live[23]
    |=> grant_o.num == 5'd22)
    else $error("timer 1 lower half misrouted");
  chk_idle_lines: assert property (
    req[4] == 1'b0 && req[21] == 1'b0 && req[17:15] == 3'h0
      && req[13:9] == 5'h00)
    else $error("unassigned request line active");
  chk_status_hold: assert property (
    status[ST_WIN] && st_clr[ST_WIN] == 1'b0 |=> status[ST_WIN])
    else $error("sticky status lost");
  chk_irq_level: assert property (
    status[ST_WIN] && irq_mask[ST_WIN] |-> irq_o)
    else $error("interrupt not raised");

  // ---------------------------------------------------------------
  // Routing, bus and event checks
  // ---------------------------------------------------------------
  chk_winner_live: assert property (
    found |-> live[best_num])
    else $error("winner is not an active request");
  chk_ext_pair: assert property (
    src_i.ext7 && mask[REQ_EXT37] && level[7:6] == 2'h0
      && live[2:0] == 3'h0
    |=> grant_o.num == 5'd3)
    else $error("channel 7 did not reach request 3");
  chk_ext5_route: assert property (
    src_i.ext5 && mask[REQ_EXT5] && level[3:2] == 2'h0 && !live[0]
    |=> grant_o.num == 5'd1 && grant_o.vec_upper == 16'hfff8)
    else $error("channel 5 did not reach request 1");
  chk_timer0_map: assert property (
    src_i.tmr0_hi && mask[REQ_TMR0_HI] && live[5:0] == 6'h00
      && level[13:12] == 2'h0
    |=> grant_o.num == 5'd6)
    else $error("timer 0 upper half misrouted");
  chk_serial_map: assert property (
    live == 24'h000080 && src_i.ser_rx |=> grant_o.num == 5'd7)
    else $error("serial receive misrouted");
  chk_flash_vec: assert property (
    live == 24'h800000 |=> grant_o.num == 5'd23
      && grant_o.vec_upper == 16'hffcc && grant_o.vec_lower == 16'hffcd)
    else $error("last request vector wrong");
  chk_first_vec: assert property (
    live[0] && level[1:0] == 2'h0
    |=> grant_o.vec_upper == 16'hfffa && grant_o.vec_lower == 16'hfffb)
    else $error("first request vector wrong");
  chk_grant_idle: assert property (
    !found |=> !grant_o.valid)
    else $error("grant without request");
  chk_ack_pulse: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_dat_quiet: assert property (
    !ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  chk_status_set: assert property (
    st_set[ST_WIN] |=> status[ST_WIN])
    else $error("event did not set status");
  chk_irq_quiet: assert property (
    (status & irq_mask) == 2'h0 |-> !irq_o)
    else $error("interrupt without unmasked status");

  // Main scenarios the bench should reach
  cov_grant: cover property (found ##1 grant_o.valid);
  cov_tie: cover property (live[0] && live[1] && level[3:0] == 4'h0);
  cov_irq: cover property (!irq_o ##1 irq_o);
  cov_vec23: cover property (grant_o.valid && grant_o.num == 5'd23);
  cov_ovr: cover property (ev_ovr);
endmodule

//--- shared/irq_map_pkg.sv
// Package of constants and types for the vectored interrupt priority map
package irq_map_pkg;
  // ---------------------------------------------------------------
  // Sizes and vector layout
  // ---------------------------------------------------------------
  localparam int unsigned NUM_REQ = 24;
  localparam logic [15:0] VEC_BASE = 16'hfffa;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  localparam logic [1:0] LEVEL_RESET = 2'h3;
  // ---------------------------------------------------------------
  // Fixed request numbers of sources
  // ---------------------------------------------------------------
  localparam int unsigned REQ_EXT4 = 0;
  localparam int unsigned REQ_EXT5 = 1;
  localparam int unsigned REQ_EXT26 = 2;
  localparam int unsigned REQ_EXT37 = 3;
  localparam int unsigned REQ_TMR0_LO = 5;
  localparam int unsigned REQ_TMR0_HI = 6;
  localparam int unsigned REQ_SER_RX = 7;
  localparam int unsigned REQ_SER_TX = 8;
  localparam int unsigned REQ_TMR1_HI = 14;
  localparam int unsigned REQ_ADC = 18;
  localparam int unsigned REQ_TBT = 19;
  localparam int unsigned REQ_WPS = 20;
  localparam int unsigned REQ_TMR1_LO = 22;
  localparam int unsigned REQ_FLASH = 23;
  // ---------------------------------------------------------------
  // Register map (word offsets, byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_LEVEL0 = 8'h00;
  localparam logic [7:0] ADDR_LEVEL1 = 8'h04;
  localparam logic [7:0] ADDR_PENDING = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_WINNER = 8'h14;
  // Status bits: new winner, live request rising while the core takes a grant
  localparam int unsigned ST_WIN = 0;
  localparam int unsigned ST_OVR = 1;
  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ext2, ext3, ext4, ext5, ext6, ext7;
    logic tmr0_lo, tmr0_hi, tmr1_lo, tmr1_hi;
    logic ser_rx, ser_tx, adc, tbt, wps, flash;
  } src_t;
  typedef struct packed {
    logic valid;
    logic [4:0] num;
    logic [1:0] level;
    logic [15:0] vec_upper;
    logic [15:0] vec_lower;
  } grant_t;
endpackage

//--- testbench/cpu_fetch_model.sv
// Behavioural CPU core that takes granted vectors after a delay
`timescale 1ns/1ns
module cpu_fetch_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Grant and fetch delay in cycles
  input irq_map_pkg::grant_t grant_i,
  input wire logic [3:0] delay_i,
  // Vector taken, one-cycle pulse
  output logic take_o
);
  import irq_map_pkg::*;
  logic [3:0] wait_cnt; // Cycles spent on the current grant
  // Take a standing grant once the delay has run out
  always_ff @(posedge clk_i) begin
    if (rst_i || !grant_i.valid || take_o) begin
      wait_cnt <= 4'h0;
      take_o <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
      take_o <= (wait_cnt >= delay_i);
    end
  end
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the vectored interrupt priority map
`timescale 1ns/1ns
module testbench;
  import irq_map_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf, dly = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic ack_o, irq_o, take_i;
  src_t src_i = '0, s;
  grant_t grant_o;
  logic [47:0] lv; // Level fields as the bench set them
  logic [23:0] en; // Request enables as the bench set them
  int n_errors = 0, n_tests = 0, cycles = 0;
  // Request number of each source bit, top bit first
  int num_tab[16] = '{2, 3, 0, 1, 2, 3, 5, 6, 22, 14, 7, 8, 18, 19, 20, 23};
  logic [7:0] r_adr[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
  logic [31:0] r_val[7] = '{32'hffffff, 32'hffffff, 32'h0, 32'h0,
    32'hffffff, 32'h00fffa60, 32'h0};
  always #20 clk_i = ~clk_i;
  vectored_irq_priority_map u_vectored_irq_priority_map (.clk_i(clk_i),
    .rst_i(rst_i), .src_i(src_i), .take_i(take_i), .grant_o(grant_o),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_o(irq_o));
  cpu_fetch_model u_cpu_fetch_model (.clk_i(clk_i), .rst_i(rst_i),
    .grant_i(grant_o), .delay_i(dly), .take_o(take_i));
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_grant(input grant_t got, input grant_t exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    // Wait for ack however long it takes; the hang guard ends a stall
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic [23:0] req_of(input src_t v);
    logic [23:0] r;
    r = '0;
    for (int j = 0; j < 16; j++) if (v[15-j]) r[num_tab[j]] = 1'b1;
    return r;
  endfunction
  // Lowest level value wins, then lowest request number
  function automatic grant_t exp_grant(input src_t v);
    grant_t g;
    logic [23:0] r;
    g = '0;
    g.level = 2'h3; // Idle grant shows the lowest level and request 0
    g.vec_upper = 16'hfffa;
    g.vec_lower = 16'hfffb;
    r = req_of(v) & en;
    for (int n = 0; n < 24; n++) begin
      if (r[n] && (!g.valid || lv[2*n +: 2] < g.level)) begin
        g.valid = 1'b1;
        g.num = 5'(n);
        g.level = lv[2*n +: 2];
        g.vec_upper = 16'hfffa - 16'(2 * n);
        g.vec_lower = g.vec_upper + 16'h0001;
      end
    end
    return g;
  endfunction
  task automatic apply(input src_t v);
    src_i <= v;
    repeat (3) @(posedge clk_i);
    cmp_grant(grant_o, exp_grant(v));
  endtask
  task automatic set_cfg();
    wb(1'b1, 8'h00, {8'h00, lv[23:0]}, rd);
    wb(1'b1, 8'h04, {8'h00, lv[47:24]}, rd);
    wb(1'b1, 8'h10, {8'h00, en}, rd);
  endtask
  initial begin
    void'($urandom(32'h299d6815));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values; the unmapped place ignores the write
    wb(1'b1, 8'h1c, 32'hffffffff, rd);
    foreach (r_adr[i]) begin
      wb(1'b0, r_adr[i], 32'h0, rd);
      cmp32(rd, r_val[i]);
    end
    lv = '1;
    en = '1;
    // Each source alone, then all at one level
    for (int i = 0; i < 17; i++) begin
      s = (i == 16) ? src_t'(16'hffff) : src_t'(16'h8000 >> i);
      apply(s);
      wb(1'b0, 8'h08, 32'h0, rd);
      cmp32(rd, {8'h00, req_of(s)});
    end
    // Random levels, enables, sources and fetch delays
    for (int i = 0; i < 50; i++) begin
      lv = {16'($urandom), $urandom};
      if (i % 3 == 0) lv = {24{lv[1:0]}};
      en = (i % 4 == 3) ? 24'($urandom) : 24'hffffff;
      dly <= 4'($urandom);
      set_cfg();
      wb(1'b0, 8'h04, 32'h0, rd);
      cmp32(rd, {8'h00, lv[47:24]});
      apply(src_t'($urandom));
    end
    // Interrupt raised while masked, then unmasked, then cleared
    lv = '1;
    en = '1;
    set_cfg();
    apply('0);
    wb(1'b1, 8'h0c, 32'h3, rd);
    apply(src_t'(16'h2000));
    cmp32({31'h0, irq_o}, 32'h0);
    wb(1'b0, 8'h0c, 32'h0, rd);
    cmp32(rd & 32'h1, 32'h1);
    wb(1'b1, 8'h10, 32'h01ffffff, rd);
    cmp32({31'h0, irq_o}, 32'h1);
    wb(1'b1, 8'h0c, 32'h1, rd);
    cmp32({31'h0, irq_o}, 32'h0);
    stop_test();
  end
endmodule
